// File: logic/lpc_isa_bridge.v
/*
 * Host LPC target that turns forwarded I/O and memory cycles into
 * expansion bus cycles, with address decode, fixed DMA/refresh pins
 * and gated interrupt lines.
 * Assumes the LPC host runs on ref_clk, and that expansion bus ready,
 * width and interrupt inputs are asynchronous and pass through input_sync.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lpc_isa_bridge_regs.vh"

// Three-stage synchroniser; a change is taken once stages two and three agree
module input_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Data
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  wire [WIDTH-1:0] agree;

  assign agree = ~(s2_reg ^ s3_reg);

  // Stage one feeds stage two only
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q <= INIT;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q <= (q & ~agree) | (s3_reg & agree);
    end
  end
endmodule

// Functional notes
// - Host LPC cycles become expansion bus cycles
// - Bridge is the only expansion bus master
// - Refresh output held high, never generated
// - DMA acknowledges held high, requests ignored
// - Terminal count output held low always
// - Both 8-bit and 16-bit I/O cycles
// - Forward only addresses nobody else claims
// - 0xC80-0xCCF stays on board, never forwarded
// - 0x2E/0x2F and 0xC00-0xC7F always blocked
// - Four serial ports on by default, blocked
// - Each enabled port with a select of 0-9 hides one 8-byte window
// - Ten selectable serial port base addresses
// - Memory 0xA0000-0xB7FFF forwarded, nothing else
// - Only IRQ 3-7, 9-12, 15 accepted
// - Per-line IRQ enables, all off at reset
// - IRQ lines unshared, one driver each
module lpc_isa_bridge (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Host LPC side
  input wire lframe_n,
  input wire [3:0] lad_in,
  output reg [3:0] lad_out,
  output reg lad_oe_n,
  input wire other_claim,
  // Configuration load from the on-board setup logic
  input wire cfg_load,
  input wire [3:0] cfg_com_en,
  input wire [15:0] cfg_com_sel,
  input wire [9:0] cfg_irq_en,
  // Expansion bus address and strobes
  output reg [19:0] sa,
  output reg sbhe_n,
  output reg bale,
  output reg aen,
  output reg ior_n,
  output reg iow_n,
  output reg memr_n,
  output reg memw_n,
  // Expansion bus data
  input wire [15:0] sd_in,
  output reg [15:0] sd_out,
  output reg sd_oe_n,
  // Expansion bus handshakes
  input wire iochrdy,
  input wire iocs16_n,
  // Fixed pins of unsupported features
  output reg refresh_n,
  output reg [6:0] dack_n,
  output reg tc,
  // Interrupts: lines 3,4,5,6,7,9,10,11,12,15 in bits 0 to 9
  input wire [9:0] isa_irq,
  output reg [9:0] irq_req
);
  // Host cycle states
  localparam [3:0] L_IDLE = 4'h0;
  localparam [3:0] L_CTYPE = 4'h1;
  localparam [3:0] L_ADDR = 4'h2;
  localparam [3:0] L_WDATA = 4'h3;
  localparam [3:0] L_TAR = 4'h4;
  localparam [3:0] L_TARB = 4'h5;
  localparam [3:0] L_SYNC = 4'h6;
  localparam [3:0] L_READY = 4'h7;
  localparam [3:0] L_RDAT = 4'h8;
  localparam [3:0] L_RDATB = 4'h9;
  localparam [3:0] L_DTAR = 4'ha;

  // Expansion bus states
  localparam [2:0] I_IDLE = 3'h0;
  localparam [2:0] I_ADDR = 3'h1;
  localparam [2:0] I_SETUP = 3'h2;
  localparam [2:0] I_CMD = 3'h3;
  localparam [2:0] I_WAIT = 3'h4;
  localparam [2:0] I_REC = 3'h5;

  localparam integer SETUP_INT = `NS_TO_CYC(`ADDR_SETUP_NS);
  localparam integer CMD8_INT = `NS_TO_CYC(`CMD8_NS);
  localparam integer CMD16_INT = `NS_TO_CYC(`CMD16_NS);
  localparam integer REC_INT = `NS_TO_CYC(`RECOVERY_NS);
  localparam [4:0] SETUP_CYC = SETUP_INT[4:0];
  localparam [4:0] CMD8_CYC = CMD8_INT[4:0];
  localparam [4:0] CMD16_CYC = CMD16_INT[4:0];
  localparam [4:0] REC_CYC = REC_INT[4:0];

  reg [3:0] lstate_reg;
  reg [3:0] lstate_next;
  reg cyc_mem_reg;
  reg cyc_wr_reg;
  reg [31:0] addr_reg;
  reg [2:0] nib_cnt_reg;
  reg [7:0] wdata_reg;
  reg [7:0] rdata_reg;
  reg started_reg;
  reg isa_start_reg;
  reg isa_done_reg;
  reg [2:0] istate_reg;
  reg [4:0] icnt_reg;
  reg wide_reg;
  reg [3:0] com_en_reg;
  reg [15:0] com_sel_reg;
  reg [9:0] irq_en_reg;
  reg [3:0] lad_next;
  reg lad_oe_n_next;
  reg blocked;
  reg forward;
  reg [15:0] base;
  integer i;
  wire [11:0] sync_q;
  wire iochrdy_s;
  wire iocs16_n_s;
  wire [9:0] irq_s;
  wire [15:0] io_addr;
  wire isa_idle;

  assign io_addr = addr_reg[15:0];
  assign isa_idle = (istate_reg == I_IDLE) && !isa_start_reg;
  assign iochrdy_s = sync_q[0];
  assign iocs16_n_s = sync_q[1];
  assign irq_s = sync_q[11:2];

  // Ready, width and interrupt pins from the expansion bus are asynchronous to ref_clk
  input_sync #(
    .WIDTH(12),
    .INIT(12'h003)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .d({isa_irq, iocs16_n, iochrdy}),
    .q(sync_q)
  );

  // Base address of a serial port selection; zero means unusable
  function [15:0] com_base;
    input [3:0] sel;
    begin
      case (sel)
        4'h0: com_base = `COM_BASE_0;
        4'h1: com_base = `COM_BASE_1;
        4'h2: com_base = `COM_BASE_2;
        4'h3: com_base = `COM_BASE_3;
        4'h4: com_base = `COM_BASE_4;
        4'h5: com_base = `COM_BASE_5;
        4'h6: com_base = `COM_BASE_6;
        4'h7: com_base = `COM_BASE_7;
        4'h8: com_base = `COM_BASE_8;
        4'h9: com_base = `COM_BASE_9;
        default: com_base = 16'h0000;
      endcase
    end
  endfunction

  // Address decode: what stays on board and what goes out
  always @* begin
    base = 16'h0000;
    blocked = (io_addr == `CFG_INDEX_PORT) || (io_addr == `CFG_DATA_PORT) ||
              (io_addr >= `RUNTIME_LO && io_addr <= `RUNTIME_HI);
    blocked = blocked || (io_addr >= `ONBOARD_LO && io_addr <= `ONBOARD_HI);
    for (i = 0; i < 4; i = i + 1) begin
      base = com_base(com_sel_reg[i*4 +: 4]);
      if (com_en_reg[i] && com_sel_reg[i*4 +: 4] <= `COM_SEL_MAX && io_addr[15:3] == base[15:3]) begin
        blocked = 1'b1;
      end
    end
    if (cyc_mem_reg) begin
      forward = !other_claim && addr_reg >= `MEM_WIN_LO && addr_reg <= `MEM_WIN_HI;
    end else begin
      forward = !other_claim && !blocked;
    end
  end

  // Host cycle sequencing
  always @* begin
    lstate_next = lstate_reg;
    case (lstate_reg)
      L_IDLE: begin
        if (!lframe_n && lad_in == 4'h0) begin
          lstate_next = L_CTYPE;
        end
      end
      L_CTYPE: begin
        if (!lframe_n) begin
          lstate_next = (lad_in == 4'h0) ? L_CTYPE : L_IDLE;
        end else if (lad_in[3] || lad_in[0]) begin
          lstate_next = L_IDLE;
        end else begin
          lstate_next = L_ADDR;
        end
      end
      L_ADDR: begin
        if (nib_cnt_reg == 3'h0) begin
          lstate_next = cyc_wr_reg ? L_WDATA : L_TAR;
        end
      end
      L_WDATA: begin
        if (nib_cnt_reg == 3'h0) begin
          lstate_next = L_TAR;
        end
      end
      L_TAR: lstate_next = L_TARB;
      L_TARB: lstate_next = forward ? L_SYNC : L_IDLE;
      L_SYNC: begin
        if (started_reg && isa_done_reg) begin
          lstate_next = L_READY;
        end
      end
      L_READY: lstate_next = cyc_wr_reg ? L_DTAR : L_RDAT;
      L_RDAT: lstate_next = L_RDATB;
      L_RDATB: lstate_next = L_DTAR;
      L_DTAR: lstate_next = L_IDLE;
      default: lstate_next = L_IDLE;
    endcase
    // An abort from the host ends any cycle past the type nibble
    if (!lframe_n && lstate_reg != L_IDLE && lstate_reg != L_CTYPE) begin
      lstate_next = (lad_in == 4'h0) ? L_CTYPE : L_IDLE;
    end
  end

  // What the bridge drives onto LAD in the next state
  always @* begin
    lad_next = `LAD_IDLE;
    lad_oe_n_next = 1'b0;
    case (lstate_next)
      L_SYNC: lad_next = `SYNC_LONG_WAIT;
      L_READY: lad_next = `SYNC_READY;
      L_RDAT: lad_next = rdata_reg[3:0];
      L_RDATB: lad_next = rdata_reg[7:4];
      L_DTAR: lad_next = `LAD_IDLE;
      default: lad_oe_n_next = 1'b1;
    endcase
  end

  // Host cycle registers
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      lstate_reg <= L_IDLE;
      cyc_mem_reg <= 1'b0;
      cyc_wr_reg <= 1'b0;
      addr_reg <= 32'h00000000;
      nib_cnt_reg <= 3'h0;
      wdata_reg <= 8'h00;
      started_reg <= 1'b0;
      isa_start_reg <= 1'b0;
      lad_out <= `LAD_IDLE;
      lad_oe_n <= 1'b1;
    end else begin
      lstate_reg <= lstate_next;
      lad_out <= lad_next;
      lad_oe_n <= lad_oe_n_next;
      isa_start_reg <= 1'b0;
      if (lstate_reg == L_CTYPE) begin
        cyc_wr_reg <= lad_in[`CT_DIR_BIT];
        cyc_mem_reg <= lad_in[`CT_MEM_BIT];
        nib_cnt_reg <= lad_in[`CT_MEM_BIT] ? 3'h7 : 3'h3;
        addr_reg <= 32'h00000000;
      end
      // Address arrives most significant nibble first
      if (lstate_reg == L_ADDR) begin
        addr_reg <= {addr_reg[27:0], lad_in};
        nib_cnt_reg <= (nib_cnt_reg == 3'h0) ? 3'h1 : nib_cnt_reg - 3'h1;
      end
      // Write data arrives low nibble first
      if (lstate_reg == L_WDATA) begin
        wdata_reg <= {lad_in, wdata_reg[7:4]};
        nib_cnt_reg <= nib_cnt_reg - 3'h1;
      end
      if (lstate_reg == L_TARB) begin
        started_reg <= 1'b0;
      end
      if (lstate_reg == L_SYNC && !started_reg && isa_idle) begin
        isa_start_reg <= 1'b1;
        started_reg <= 1'b1;
      end
    end
  end

  // Decode and interrupt settings, loaded by the on-board setup logic
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      com_en_reg <= `COM_EN_RESET;
      com_sel_reg <= `COM_SEL_RESET;
      irq_en_reg <= `IRQ_EN_RESET;
    end else if (cfg_load) begin
      com_en_reg <= cfg_com_en;
      com_sel_reg <= cfg_com_sel;
      irq_en_reg <= cfg_irq_en;
    end
  end

  // Expansion bus cycle engine; the only driver of the command strobes
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      istate_reg <= I_IDLE;
      icnt_reg <= 5'h00;
      wide_reg <= 1'b0;
      isa_done_reg <= 1'b0;
      rdata_reg <= 8'h00;
      sa <= 20'h00000;
      sbhe_n <= 1'b1;
      bale <= 1'b0;
      ior_n <= 1'b1;
      iow_n <= 1'b1;
      memr_n <= 1'b1;
      memw_n <= 1'b1;
      sd_out <= 16'h0000;
      sd_oe_n <= 1'b1;
    end else begin
      isa_done_reg <= 1'b0;
      case (istate_reg)
        I_IDLE: begin
          if (isa_start_reg) begin
            sa <= addr_reg[19:0];
            sbhe_n <= ~addr_reg[0];
            bale <= 1'b1;
            // Writes put the byte on both lanes, so either module width takes it
            sd_out <= {wdata_reg, wdata_reg};
            sd_oe_n <= ~cyc_wr_reg;
            icnt_reg <= SETUP_CYC;
            istate_reg <= I_ADDR;
          end
        end
        I_ADDR: begin
          bale <= 1'b0;
          istate_reg <= I_SETUP;
        end
        // Setup covers the synchroniser delay on the width reply
        I_SETUP: begin
          if (icnt_reg <= 5'h01) begin
            wide_reg <= !cyc_mem_reg && !iocs16_n_s;
            icnt_reg <= (!cyc_mem_reg && !iocs16_n_s) ? CMD16_CYC : CMD8_CYC;
            ior_n <= cyc_mem_reg || cyc_wr_reg;
            iow_n <= cyc_mem_reg || !cyc_wr_reg;
            memr_n <= !cyc_mem_reg || cyc_wr_reg;
            memw_n <= !cyc_mem_reg || !cyc_wr_reg;
            istate_reg <= I_CMD;
          end else begin
            icnt_reg <= icnt_reg - 5'h01;
          end
        end
        I_CMD: begin
          if (icnt_reg <= 5'h01) begin
            istate_reg <= I_WAIT;
          end else begin
            icnt_reg <= icnt_reg - 5'h01;
          end
        end
        // A module stretches the command by pulling ready low
        I_WAIT: begin
          if (iochrdy_s) begin
            rdata_reg <= (wide_reg && sa[0]) ? sd_in[15:8] : sd_in[7:0];
            ior_n <= 1'b1;
            iow_n <= 1'b1;
            memr_n <= 1'b1;
            memw_n <= 1'b1;
            icnt_reg <= REC_CYC;
            istate_reg <= I_REC;
          end
        end
        I_REC: begin
          sd_oe_n <= 1'b1;
          if (icnt_reg <= 5'h01) begin
            isa_done_reg <= 1'b1;
            istate_reg <= I_IDLE;
          end else begin
            icnt_reg <= icnt_reg - 5'h01;
          end
        end
        default: istate_reg <= I_IDLE;
      endcase
    end
  end

  // Pins of features the bridge leaves out; held as constant flops
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      aen <= 1'b0;
      refresh_n <= 1'b1;
      dack_n <= 7'h7f;
      tc <= 1'b0;
    end else begin
      aen <= 1'b0;
      refresh_n <= 1'b1;
      dack_n <= 7'h7f;
      tc <= 1'b0;
    end
  end

  // Interrupts pass only where enabled; one module per line is assumed
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_req <= 10'h000;
    end else begin
      irq_req <= irq_s & irq_en_reg;
    end
  end
endmodule
`default_nettype wire

// File: logic/lpc_isa_bridge_regs.vh
/*
 * Constants of the host-to-expansion-bus bridge: address decode windows,
 * serial port base table, power-up settings and expansion bus timing.
 * Assumes inclusion by the bridge design file only; definitions only.
 */
`ifndef LPC_ISA_BRIDGE_REGS_VH
`define LPC_ISA_BRIDGE_REGS_VH

// Clock rate used to turn times into cycle counts
`define REF_CLK_KHZ 20000

// Expansion bus timing in ns; least times round up to whole cycles
`define ADDR_SETUP_NS 200
`define CMD8_NS 500
`define CMD16_NS 200
`define RECOVERY_NS 150
`define NS_TO_CYC(ns) (((ns) * `REF_CLK_KHZ + 999999) / 1000000)

// Host cycle type nibble fields
`define CT_DIR_BIT 1
`define CT_MEM_BIT 2

// Host sync nibbles
`define SYNC_LONG_WAIT 4'h5
`define SYNC_READY 4'h0
`define LAD_IDLE 4'hf

// On-board I/O windows never sent to the expansion bus
`define CFG_INDEX_PORT 16'h002e
`define CFG_DATA_PORT 16'h002f
`define RUNTIME_LO 16'h0c00
`define RUNTIME_HI 16'h0c7f
`define ONBOARD_LO 16'h0c80
`define ONBOARD_HI 16'h0ccf

// Memory window forwarded to the expansion bus
`define MEM_WIN_LO 32'h000a0000
`define MEM_WIN_HI 32'h000b7fff

// Selectable serial port bases, index 0 to 9
`define COM_BASE_0 16'h0200
`define COM_BASE_1 16'h0208
`define COM_BASE_2 16'h0220
`define COM_BASE_3 16'h0228
`define COM_BASE_4 16'h0238
`define COM_BASE_5 16'h02e8
`define COM_BASE_6 16'h02f8
`define COM_BASE_7 16'h0338
`define COM_BASE_8 16'h03e8
`define COM_BASE_9 16'h03f8
`define COM_SEL_MAX 4'h9

// Power-up settings: all four ports on at 3F8, 2F8, 3E8, 2E8; IRQs off
`define COM_EN_RESET 4'hf
`define COM_SEL_RESET 16'h5869
`define IRQ_EN_RESET 10'h000

`endif

// File: sim/isa_module_model.sv
/*
 Expansion module model: byte responder with optional 16-bit decode and waits.
 Assumes the bridge's expansion bus; iochrdy and iocs16_n have pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module isa_module_model (
  // Clock
  input wire logic ref_clk,
  // Bus from bridge
  input wire logic [19:0] sa,
  input wire logic aen,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic memr_n,
  input wire logic memw_n,
  input wire logic [15:0] sd_out,
  input wire logic sd_oe_n,
  // Answer to bridge
  output logic [15:0] sd_in,
  output logic iochrdy,
  output logic iocs16_n,
  // Bench controls
  input wire logic wide,
  input wire logic slow
);
  logic [15:0] last_reg;
  logic [7:0] wr_byte;
  logic [3:0] wait_reg;
  logic cmd_reg;
  wire rd = !ior_n || !memr_n;
  wire wr = !iow_n || !memw_n;
  assign iocs16_n = !(wide && !aen && sa[11:4] == 8'h30);
  // Released lines toggle so a stale sample is caught
  assign sd_in = rd ? {sa[7:0] ^ 8'ha5, sa[7:0] ^ 8'h5a} : ~last_reg;
  // the model answers only and never bids for the bus
  assign iochrdy = !(slow && wait_reg != 4'h0);
  // Wait count from command start; write byte taken while strobe is low
  always @(posedge ref_clk) begin
    last_reg <= sd_in;
    cmd_reg <= rd || wr;
    if ((rd || wr) && !cmd_reg)
      wait_reg <= 4'h6;
    else if (wait_reg != 4'h0)
      wait_reg <= wait_reg - 4'h1;
    // Undriven data lines read back inverted, so a missing enable shows
    if (wr)
      wr_byte <= sd_oe_n ? ~sd_out[7:0] : sd_out[7:0];
  end
endmodule
`default_nettype wire

// File: sim/lpc_isa_bridge_properties.sv
/*
 Checker for the bridge's expansion bus and fixed pins.
 Assumes binding to the bridge top; one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_isa_bridge_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Watched ports
  input wire logic cfg_load,
  input wire logic [3:0] lad_out,
  input wire logic lad_oe_n,
  input wire logic [19:0] sa,
  input wire logic sbhe_n,
  input wire logic bale,
  input wire logic aen,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic memr_n,
  input wire logic memw_n,
  input wire logic [15:0] sd_out,
  input wire logic sd_oe_n,
  input wire logic refresh_n,
  input wire logic [6:0] dack_n,
  input wire logic tc,
  input wire logic [9:0] irq_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire cmd_hi = ior_n && iow_n && memr_n && memw_n;
  logic loaded_reg;
  // Interrupts may only pass once enables were loaded
  always @(posedge ref_clk) begin
    if (!reset_n)
      loaded_reg <= 1'b0;
    else if (cfg_load)
      loaded_reg <= 1'b1;
  end
  sequence s_addr;
    bale ##1 (!bale && cmd_hi) [*3];
  endsequence
  sequence s_mem_cmd;
    !memr_n [*8] ##1 !memr_n [*2];
  endsequence
  property p_refresh; refresh_n; endproperty
  property p_dack; dack_n == 7'h7f; endproperty
  property p_tc; !tc; endproperty
  property p_master; !aen; endproperty
  property p_one_cmd; $onehot0({!ior_n, !iow_n, !memr_n, !memw_n}); endproperty
  property p_setup; bale |-> s_addr; endproperty
  property p_io_width; $fell(ior_n) |-> !ior_n [*4]; endproperty
  property p_mem_width; $fell(memr_n) |-> s_mem_cmd; endproperty
  property p_sbhe; bale |-> sbhe_n == !sa[0]; endproperty
  property p_lanes; !sd_oe_n |-> sd_out[15:8] == sd_out[7:0]; endproperty
  property p_rd_float; (!ior_n || !memr_n) |-> sd_oe_n; endproperty
  property p_sync; $fell(lad_oe_n) |-> lad_out == 4'h5; endproperty
  property p_irq_off; !loaded_reg |-> irq_req == 10'h000; endproperty
  property p_wr_drive; (!iow_n || !memw_n) |-> !sd_oe_n; endproperty
  a_refresh: assert property (p_refresh) else $error("refresh low");
  a_dack: assert property (p_dack) else $error("dma acknowledge low");
  a_tc: assert property (p_tc) else $error("terminal count high");
  a_master: assert property (p_master) else $error("address enable high");
  a_one_cmd: assert property (p_one_cmd) else $error("two strobes low");
  a_setup: assert property (p_setup) else $error("short address setup");
  a_io_width: assert property (p_io_width) else $error("short io strobe");
  a_mem_width: assert property (p_mem_width) else $error("short mem strobe");
  a_sbhe: assert property (p_sbhe) else $error("byte high enable wrong");
  a_lanes: assert property (p_lanes) else $error("write lanes differ");
  a_rd_float: assert property (p_rd_float) else $error("data driven on read");
  a_sync: assert property (p_sync) else $error("first sync not wait");
  a_irq_off: assert property (p_irq_off) else $error("irq before enable");
  a_wr_drive: assert property (p_wr_drive) else $error("data not driven on write");
endmodule
bind lpc_isa_bridge lpc_isa_bridge_properties i_lpc_isa_bridge_properties (.ref_clk, .reset_n, .cfg_load,
  .lad_out, .lad_oe_n, .sa, .sbhe_n, .bale, .aen, .ior_n, .iow_n, .memr_n, .memw_n, .sd_out, .sd_oe_n,
  .refresh_n, .dack_n, .tc, .irq_req);
`default_nettype wire

// File: sim/lpc_isa_bridge_test.sv
/*
 Self-checking bench: host cycles, decode table, port selects, memory, irqs.
 Assumes the module model and checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_isa_bridge_test;
  logic ref_clk = 0, reset_n = 0, lframe_n = 1, other_claim = 0, cfg_load = 0, wide = 0, slow = 0;
  logic [3:0] host_lad = 4'hf, lad_out, cfg_com_en = 4'hf;
  logic lad_oe_n, sbhe_n, bale, aen, ior_n, iow_n, memr_n, memw_n, sd_oe_n, iochrdy, iocs16_n, refresh_n, tc;
  logic [15:0] cfg_com_sel = 16'h5869, sd_in, sd_out;
  logic [9:0] cfg_irq_en = 10'h000, isa_irq = 10'h3ff, irq_req;
  logic [19:0] sa;
  logic [6:0] dack_n;
  logic [7:0] wd;
  int error_cnt = 0, n_tests = 0;
  int bases [10] = '{16'h0200, 16'h0208, 16'h0220, 16'h0228, 16'h0238, 16'h02e8, 16'h02f8, 16'h0338,
    16'h03e8, 16'h03f8};
  int probe [18] = '{16'h002e, 16'h002f, 16'h0c00, 16'h0c7f, 16'h0c80, 16'h0ccf, 16'h03f8, 16'h03ff,
    16'h02f8, 16'h02ff, 16'h03e8, 16'h03ef, 16'h02e8, 16'h02ef, 16'h02f7, 16'h0cd0, 16'h0bff, 16'h002d};
  logic [31:0] mems [5] = '{32'h000a0000, 32'h000b7fff, 32'h0009ffff, 32'h000b8000, 32'h100a0000};
  // LAD has a pull-up: host floats to f
  wire [3:0] lad_in = lad_oe_n ? host_lad : lad_out;
  wire cmd_hi = ior_n & iow_n & memr_n & memw_n;
  always #25 ref_clk = ~ref_clk;
  lpc_isa_bridge i_lpc_isa_bridge (.ref_clk, .reset_n, .lframe_n, .lad_in, .lad_out, .lad_oe_n,
    .other_claim, .cfg_load, .cfg_com_en, .cfg_com_sel, .cfg_irq_en, .sa, .sbhe_n, .bale, .aen, .ior_n,
    .iow_n, .memr_n, .memw_n, .sd_in, .sd_out, .sd_oe_n, .iochrdy, .iocs16_n, .refresh_n, .dack_n, .tc,
    .isa_irq, .irq_req);
  isa_module_model i_isa_module_model (.ref_clk, .sa, .aen, .ior_n, .iow_n, .memr_n, .memw_n, .sd_out,
    .sd_oe_n, .sd_in, .iochrdy, .iocs16_n, .wide, .slow);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reference decode from the bench's copy of the settings
  function automatic bit fwd(logic [31:0] a, bit mem);
    if (mem)
      return a >= 32'h000a0000 && a <= 32'h000b7fff;
    if (other_claim || a == 32'h2e || a == 32'h2f || (a >= 32'hc00 && a <= 32'hccf))
      return 0;
    for (int i = 0; i < 4; i++)
      if (cfg_com_en[i] && cfg_com_sel[4*i+:4] <= 4'h9 && a / 8 == bases[cfg_com_sel[4*i+:4]] / 8)
        return 0;
    return 1;
  endfunction
  // high lane only for a 16-bit odd access
  function automatic logic [7:0] exp_rd(logic [31:0] a, bit mem);
    return a[7:0] ^ ((!mem && wide && a[11:4] == 8'h30 && a[0]) ? 8'ha5 : 8'h5a);
  endfunction
  // Host cycle: start, type, address, data, turnaround, then sync
  task automatic lpc(input logic [3:0] ct, input logic [31:0] a, input logic [7:0] d);
    logic f;
    logic [7:0] rd;
    int n;
    f = fwd(a, ct[2]);
    n = 0;
    @(negedge ref_clk);
    lframe_n = 0;
    host_lad = 4'h0;
    @(negedge ref_clk);
    lframe_n = 1;
    host_lad = ct;
    for (int i = ct[2] ? 7 : 3; i >= 0; i--) begin
      @(negedge ref_clk);
      host_lad = a[4*i+:4];
    end
    for (int i = 0; i < (ct[1] ? 4 : 2); i++) begin
      @(negedge ref_clk);
      host_lad = (ct[1] && i < 2) ? d[4*i+:4] : 4'hf;
    end
    @(negedge ref_clk);
    check(lad_oe_n, !f);
    if (f) begin
      check(lad_out, 4'h5);
      while (lad_out === 4'h5 && n < 400) begin
        @(negedge ref_clk);
        n++;
      end
      check(lad_out, 4'h0);
      if (!ct[1]) begin
        @(negedge ref_clk);
        rd[3:0] = lad_out;
        @(negedge ref_clk);
        rd[7:4] = lad_out;
        check(rd, exp_rd(a, ct[2]));
      end else
        check(i_isa_module_model.wr_byte, d);
      @(negedge ref_clk);
      check(lad_out, 4'hf);
      @(negedge ref_clk);
      check(lad_oe_n, 1'b1);
    end else begin
      repeat (40) begin
        @(negedge ref_clk);
        n += !lad_oe_n || bale || !cmd_hi;
      end
      check(n, 0);
    end
  endtask
  // Settings load pulse
  task automatic load(input logic [3:0] en, input logic [15:0] sel, input logic [9:0] irq);
    @(negedge ref_clk);
    cfg_com_en = en;
    cfg_com_sel = sel;
    cfg_irq_en = irq;
    cfg_load = 1;
    @(negedge ref_clk);
    cfg_load = 0;
  endtask
  task automatic close_out;
    $display("%0d mismatches in %0d comparisons", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog: far beyond the few thousand cycles the tests need
  initial begin
    #3000000;
    error_cnt++;
    close_out;
  end
  // Main sequence
  initial begin
    void'($urandom(47));
    repeat (6) @(negedge ref_clk);
    reset_n = 1;
    repeat (5) @(negedge ref_clk);
    check(irq_req, 10'h000);
    foreach (probe[i]) lpc(4'h0, probe[i], 8'h00);
    wd = 8'($urandom);
    lpc(4'h2, 32'h0300, wd);
    lpc(4'h2, 32'h0c80, wd);
    wide = 1;
    lpc(4'h0, 32'h0301, 8'h00);
    lpc(4'h0, 32'h0300, 8'h00);
    wd ^= 8'($urandom) | 8'h01;
    lpc(4'h2, 32'h0301, wd);
    wide = 0;
    lpc(4'h0, 32'h0301, 8'h00);
    slow = 1;
    lpc(4'h0, 32'h0280, 8'h00);
    wd ^= 8'($urandom) | 8'h01;
    lpc(4'h2, 32'h0280, wd);
    slow = 0;
    other_claim = 1;
    lpc(4'h0, 32'h0300, 8'h00);
    other_claim = 0;
    foreach (mems[i]) lpc(4'h4, mems[i], 8'h00);
    wd ^= 8'($urandom) | 8'h01;
    lpc(4'h6, 32'h000a1234, wd);
    lpc(4'h6, 32'h000c0000, wd);
    for (int k = 0; k < 11; k++) begin
      load(4'h1, {12'hfff, k[3:0]}, 10'h000);
      lpc(4'h0, bases[k % 10] + 7, 8'h00);
    end
    lpc(4'h0, 32'h03f8, 8'h00);
    repeat (4) begin
      load(4'h1, 16'hfffa, 10'($urandom));
      isa_irq = 10'($urandom);
      repeat (8) @(negedge ref_clk);
      check(irq_req, isa_irq & cfg_irq_en);
    end
    close_out;
  end
endmodule
`default_nettype wire
